// [rtl/aam_map.svh]
`ifndef AAM_MAP_SVH
`define AAM_MAP_SVH

// Byte offsets on the APB side
`define AAM_OFF_CTRL      8'h00
`define AAM_OFF_CHEN      8'h04
`define AAM_OFF_DELAY     8'h08
`define AAM_OFF_ALARM     8'h0c
`define AAM_OFF_STATUS    8'h10
// Per-channel groups, selected by address bits 7:6, index in bits 5:2
`define AAM_GRP_GLOBAL    2'h0
`define AAM_GRP_CFG       2'h1
`define AAM_GRP_THR       2'h2
`define AAM_GRP_DATA      2'h3

// Control word fields
`define AAM_CTRL_SCAN     0
`define AAM_CTRL_ODRAIN   1
`define AAM_CTRL_POL      2
`define AAM_CTRL_AVG      4
`define AAM_CTRL_FAULT    8
// Channel configuration fields
`define AAM_CFG_DIFF      0
`define AAM_CFG_BIPOLAR   1
`define AAM_CFG_TEMP      2
// Threshold word fields
`define AAM_THR_LO        0
`define AAM_THR_HI        16

// Reset values
`define AAM_CHEN_RST      10'h3ff
`define AAM_DELAY_RST     16'h0000
`define AAM_CFG_RST       3'h0
`define AAM_THR_LO_RST    12'h000
`define AAM_THR_HI_RST    12'hfff

// Serial command codes, upper nibble of the command word
`define AAM_CMD_MANUAL    4'h0
`define AAM_CMD_RD_ALARM  4'h1
`define AAM_CMD_RD_DATA   4'h2
`define AAM_CMD_RESET     4'h7
`define AAM_CMD_CLR_ONE   4'h8
`define AAM_CMD_CLR_ALL   4'h9

// Channel numbering: 0 die temperature, 1 supply, 2..9 external 0..7
`define AAM_NCH           10
`define AAM_CH_TEMP       4'h0
`define AAM_CH_EXT0       4'h2

// Timing
`define AAM_CLK_MHZ       200
`define AAM_ACQ_NS        1500
`define AAM_VOLT_NS       10600
`define AAM_TEMP_NS       46000

`endif

// [rtl/aam_pkg.sv]
package aam_pkg;

  typedef enum logic [2:0] {
    SQ_IDLE,
    SQ_ACQ,
    SQ_CONV,
    SQ_EVAL,
    SQ_WAIT
  } aam_seq_type;

endpackage

// [rtl/aam_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module aam_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr_a,
  output logic      [WIDTH-1:0] rdata_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_b
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Out-of-range reads return zero rather than stale data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= (int'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
      rdata_b <= (int'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
    end
  end

endmodule // aam_mem

`default_nettype wire

// [rtl/aam_top.sv]
// Our own choices: the address map and the APB interface to the registers.
`include "aam_map.svh"
`timescale 1ns/1ps
`default_nettype none

module aam_top #(
  parameter int ACQ_CYC  = (`AAM_ACQ_NS * `AAM_CLK_MHZ + 999) / 1000,
  parameter int VOLT_CYC = (`AAM_VOLT_NS * `AAM_CLK_MHZ + 999) / 1000,
  parameter int TEMP_CYC = (`AAM_TEMP_NS * `AAM_CLK_MHZ + 999) / 1000
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic        DIN,
  output logic             DOUT,
  output logic             DOUT_OE,
  output logic             INT_O,
  output logic             INT_OE,
  output logic             CONV_START,
  output logic      [3:0]  CONV_CHAN,
  output logic             CONV_DIFF,
  output logic             CONV_TEMP,
  input  wire logic [11:0] CONV_DATA
);

  localparam int NCH = `AAM_NCH;
  localparam logic [13:0] ACQ_LAST  = 14'(ACQ_CYC - 1);
  localparam logic [13:0] VOLT_LAST = 14'(VOLT_CYC - 1);
  // Each of the two temperature measurements takes half the time
  localparam logic [13:0] HALF_LAST = 14'(TEMP_CYC / 2 - 1);

  // Pin synchronisers
  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, din_s1, din_s2;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3}       <= 3'h7;
      {din_s1, din_s2}            <= 2'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {SCLK, sclk_s1, sclk_s2};
      {cs_s1, cs_s2, cs_s3}       <= {CS_N, cs_s1, cs_s2};
      {din_s1, din_s2}            <= {DIN, din_s1};
    end
  end
  logic sclk_rise, sclk_fall, cs_rise;
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign cs_rise   = cs_s2 & ~cs_s3;

  // Configuration state
  logic        scan_en, odrain, pol_high;
  logic [1:0]  avg_exp;
  logic [3:0]  fault_allow;
  logic [9:0]  chen;
  logic [15:0] delay;
  logic [2:0]  cfg    [0:NCH-1];
  logic [11:0] thr_lo [0:NCH-1];
  logic [11:0] thr_hi [0:NCH-1];
  logic        next_scan_en, next_odrain, next_pol_high;
  logic [1:0]  next_avg_exp;
  logic [3:0]  next_fault_allow;
  logic [9:0]  next_chen;
  logic [15:0] next_delay;
  logic [2:0]  next_cfg    [0:NCH-1];
  logic [11:0] next_thr_lo [0:NCH-1];
  logic [11:0] next_thr_hi [0:NCH-1];

  // Sequencer and alarm state
  aam_pkg::aam_seq_type st, next_st;
  logic [3:0]  ch, next_ch, man_ch, next_man_ch;
  logic        man_pend, next_man_pend, manual, next_manual;
  logic        phase, next_phase;
  logic [15:0] timer, next_timer;
  logic [3:0]  avg_cnt, next_avg_cnt;
  logic [15:0] acc, next_acc;
  logic [11:0] first, next_first;
  logic [9:0]  alarm, next_alarm;
  logic [3:0]  fcnt [0:NCH-1];
  logic [3:0]  next_fcnt [0:NCH-1];
  logic        start_q, next_start_q;

  // Serial state
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  cmd, next_cmd;
  logic [23:0] tx, next_tx;
  logic        loaded, next_loaded;
  logic        dout_q, next_dout_q;
  logic        man_req, clr_one, clr_all, soft_rst;
  logic [7:0]  cmd_word;

  logic [11:0] mem_rd_a, mem_rd_b, res;
  logic        mem_we;

  aam_mem #(.WIDTH(12), .DEPTH(NCH), .AW(4)) u_data (
    .clk     (CLK),
    .reset_n (RESET_N),
    .we      (mem_we),
    .waddr   (ch),
    .wdata   (res),
    .raddr_a (PADDR[5:2]),
    .rdata_a (mem_rd_a),
    .raddr_b (cmd[3:0]),
    .rdata_b (mem_rd_b)
  );

  // Serial slave
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_cmd     = cmd;
    next_tx      = tx;
    next_loaded  = loaded;
    next_dout_q  = dout_q;
    man_req      = 1'b0;
    clr_one      = 1'b0;
    clr_all      = 1'b0;
    soft_rst     = 1'b0;
    cmd_word     = {cmd[6:0], din_s2};
    if (cs_s2) begin
      next_bit_cnt = 4'h0;
      next_cmd     = 8'h00;
      next_tx      = 24'h000000;
      next_loaded  = 1'b0;
      next_dout_q  = 1'b0;
      if (cs_rise && bit_cnt == 4'h8 && cmd[7:4] == `AAM_CMD_MANUAL) begin
        man_req = 1'b1;
      end
    end else begin
      if (sclk_rise && bit_cnt != 4'h8) begin
        next_cmd     = cmd_word;
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'h7) begin
          clr_one  = cmd_word[7:4] == `AAM_CMD_CLR_ONE;
          clr_all  = cmd_word[7:4] == `AAM_CMD_CLR_ALL;
          soft_rst = cmd_word[7:4] == `AAM_CMD_RESET;
        end
      end
      if (sclk_fall && bit_cnt == 4'h8) begin
        if (!loaded) begin
          next_loaded = 1'b1;
          case (cmd[7:4])
            `AAM_CMD_RD_DATA:  next_tx = {mem_rd_b, 4'h0, 8'h00};
            `AAM_CMD_RD_ALARM: next_tx = {14'h0000, alarm};
            default:           next_tx = 24'h000000;
          endcase
          next_dout_q = next_tx[23];
        end else begin
          next_tx     = {tx[22:0], 1'b0};
          next_dout_q = tx[22];
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bit_cnt <= 4'h0;
      cmd     <= 8'h00;
      tx      <= 24'h000000;
      loaded  <= 1'b0;
      dout_q  <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      cmd     <= next_cmd;
      tx      <= next_tx;
      loaded  <= next_loaded;
      dout_q  <= next_dout_q;
    end
  end

  assign DOUT    = dout_q;
  assign DOUT_OE = ~cs_s2;

  // APB slave
  logic       apb_wr, apb_setup, idx_ok;
  logic [3:0] idx;
  logic [1:0] grp;
  assign apb_wr    = PSEL & PENABLE & PWRITE;
  assign apb_setup = PSEL & ~PENABLE;
  assign idx       = PADDR[5:2];
  assign grp       = PADDR[7:6];
  assign idx_ok    = idx < 4'(NCH);
  assign PREADY    = 1'b1;

  logic [31:0] rd_mux;
  logic        bad_addr;
  always_comb begin
    rd_mux   = 32'h00000000;
    bad_addr = 1'b0;
    case (grp)
      `AAM_GRP_GLOBAL: begin
        case (PADDR)
          `AAM_OFF_CTRL:   rd_mux = {20'h00000, fault_allow, 2'h0, avg_exp,
                                     1'b0, pol_high, odrain, scan_en};
          `AAM_OFF_CHEN:   rd_mux = {22'h000000, chen};
          `AAM_OFF_DELAY:  rd_mux = {16'h0000, delay};
          `AAM_OFF_ALARM:  rd_mux = {22'h000000, alarm};
          `AAM_OFF_STATUS: rd_mux = {24'h000000, ch, 2'h0, |alarm,
                                     st != aam_pkg::SQ_IDLE};
          default:         bad_addr = 1'b1;
        endcase
      end
      `AAM_GRP_CFG: begin
        if (idx_ok) rd_mux = {29'h00000000, cfg[idx]};
        else bad_addr = 1'b1;
      end
      `AAM_GRP_THR: begin
        if (idx_ok) rd_mux = {4'h0, thr_hi[idx], 4'h0, thr_lo[idx]};
        else bad_addr = 1'b1;
      end
      default: begin
        if (idx_ok) rd_mux = {20'h00000, mem_rd_a};
        else bad_addr = 1'b1;
      end
    endcase
  end
  // Data reads come from the memory register, fetched in the setup cycle
  assign PRDATA  = (PSEL & PENABLE & ~PWRITE) ? rd_mux : 32'h00000000;
  assign PSLVERR = PSEL & PENABLE & bad_addr;

  always_comb begin
    next_scan_en     = scan_en;
    next_odrain      = odrain;
    next_pol_high    = pol_high;
    next_avg_exp     = avg_exp;
    next_fault_allow = fault_allow;
    next_chen        = chen;
    next_delay       = delay;
    for (int i = 0; i < NCH; i++) begin
      next_cfg[i]    = cfg[i];
      next_thr_lo[i] = thr_lo[i];
      next_thr_hi[i] = thr_hi[i];
    end
    if (apb_wr && !bad_addr) begin
      if (PADDR == `AAM_OFF_CTRL) begin
        next_scan_en     = PWDATA[`AAM_CTRL_SCAN];
        next_odrain      = PWDATA[`AAM_CTRL_ODRAIN];
        next_pol_high    = PWDATA[`AAM_CTRL_POL];
        next_avg_exp     = PWDATA[`AAM_CTRL_AVG +: 2];
        next_fault_allow = PWDATA[`AAM_CTRL_FAULT +: 4];
      end
      if (PADDR == `AAM_OFF_CHEN) next_chen = PWDATA[9:0];
      if (PADDR == `AAM_OFF_DELAY) next_delay = PWDATA[15:0];
      if (grp == `AAM_GRP_CFG && idx >= `AAM_CH_EXT0) begin
        next_cfg[idx] = PWDATA[2:0];
      end
      if (grp == `AAM_GRP_THR) begin
        next_thr_lo[idx] = PWDATA[`AAM_THR_LO +: 12];
        next_thr_hi[idx] = PWDATA[`AAM_THR_HI +: 12];
      end
    end
    if (soft_rst) begin
      next_scan_en     = 1'b0;
      next_odrain      = 1'b0;
      next_pol_high    = 1'b0;
      next_avg_exp     = 2'h0;
      next_fault_allow = 4'h0;
      next_chen        = `AAM_CHEN_RST;
      next_delay       = `AAM_DELAY_RST;
      for (int i = 0; i < NCH; i++) begin
        next_cfg[i]    = `AAM_CFG_RST;
        next_thr_lo[i] = `AAM_THR_LO_RST;
        next_thr_hi[i] = `AAM_THR_HI_RST;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scan_en     <= 1'b0;
      odrain      <= 1'b0;
      pol_high    <= 1'b0;
      avg_exp     <= 2'h0;
      fault_allow <= 4'h0;
      chen        <= `AAM_CHEN_RST;
      delay       <= `AAM_DELAY_RST;
      for (int i = 0; i < NCH; i++) begin
        cfg[i]    <= `AAM_CFG_RST;
        thr_lo[i] <= `AAM_THR_LO_RST;
        thr_hi[i] <= `AAM_THR_HI_RST;
      end
    end else begin
      scan_en     <= next_scan_en;
      odrain      <= next_odrain;
      pol_high    <= next_pol_high;
      avg_exp     <= next_avg_exp;
      fault_allow <= next_fault_allow;
      chen        <= next_chen;
      delay       <= next_delay;
      for (int i = 0; i < NCH; i++) begin
        cfg[i]    <= next_cfg[i];
        thr_lo[i] <= next_thr_lo[i];
        thr_hi[i] <= next_thr_hi[i];
      end
    end
  end

  // Channel capability per index
  logic [9:0] active, is_temp, is_diff, is_twos;
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // odd partner of a differential pair is never scanned alone
    if (g >= 3 && g % 2 == 1) begin : g_odd
      assign active[g] = chen[g] & ~cfg[g-1][`AAM_CFG_DIFF];
    end else begin : g_other
      assign active[g] = chen[g];
    end
    assign is_temp[g] = (g == 0) | cfg[g][`AAM_CFG_TEMP];
    // Odd channels never act as the positive side of a pair
    assign is_diff[g] = cfg[g][`AAM_CFG_DIFF] & (g < 2 || g % 2 == 0);
    assign is_twos[g] = is_temp[g] |
                        (is_diff[g] & cfg[g][`AAM_CFG_BIPOLAR]);
  end

  function automatic logic [4:0] find_ch(input logic [4:0] from,
                                         input logic [9:0] act);
    logic [4:0] f;
    f = 5'h1f;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (act[i] && 5'(i) >= from) f = 5'(i);
    end
    return f;
  endfunction

  logic [11:0] sample, raw;
  logic [15:0] sum, shifted;
  logic        avg_last, over, tmr_done;
  logic [12:0] key_r, key_hi, key_lo;
  logic [4:0]  nxt;
  logic [3:0]  fc_inc;

  always_comb begin
    next_st       = st;
    next_ch       = ch;
    next_man_ch   = man_ch;
    next_man_pend = man_pend | man_req;
    next_manual   = manual;
    next_phase    = phase;
    next_timer    = timer + 16'h0001;
    next_avg_cnt  = avg_cnt;
    next_acc      = acc;
    next_first    = first;
    next_start_q  = 1'b0;
    next_alarm    = alarm;
    for (int i = 0; i < NCH; i++) next_fcnt[i] = fcnt[i];
    if (man_req) next_man_ch = cmd[3:0];
    raw      = is_temp[ch] ? CONV_DATA - first : CONV_DATA;
    // Bipolar codes arrive offset binary; flip MSB for two's complement
    sample   = (is_twos[ch] && !is_temp[ch]) ? {~raw[11], raw[10:0]} : raw;
    sum      = acc + (is_twos[ch] ? {{4{sample[11]}}, sample}
                                  : {4'h0, sample});
    avg_last = avg_cnt == ((4'h1 << avg_exp) - 4'h1);
    shifted  = is_twos[ch] ? 16'($signed(acc) >>> avg_exp) : acc >> avg_exp;
    res      = shifted[11:0];
    // Signed compare by offsetting the sign bit
    key_r    = {1'b0, res[11] ^ is_twos[ch], res[10:0]};
    key_hi   = {1'b0, thr_hi[ch][11] ^ is_twos[ch], thr_hi[ch][10:0]};
    key_lo   = {1'b0, thr_lo[ch][11] ^ is_twos[ch], thr_lo[ch][10:0]};
    over     = (key_r > key_hi) || (key_r < key_lo);
    fc_inc   = (fcnt[ch] == 4'hf) ? 4'hf : fcnt[ch] + 4'h1;
    nxt      = find_ch(5'(ch) + 5'h01, active);
    mem_we   = 1'b0;
    tmr_done = 1'b0;
    case (st)
      aam_pkg::SQ_IDLE: begin
        next_timer = 16'h0000;
        if (man_pend) begin
          next_man_pend = man_req;
          if (man_ch < 4'(NCH)) begin
            next_ch     = man_ch;
            next_manual = 1'b1;
            next_st     = aam_pkg::SQ_ACQ;
          end
        end else if (scan_en && find_ch(5'h00, active) != 5'h1f) begin
          next_ch     = 4'(find_ch(5'h00, active));
          next_manual = 1'b0;
          next_st     = aam_pkg::SQ_ACQ;
        end
        next_avg_cnt = 4'h0;
        next_acc     = 16'h0000;
        next_phase   = 1'b0;
      end
      aam_pkg::SQ_ACQ: begin
        if (timer[13:0] == ACQ_LAST) begin
          next_timer   = 16'h0000;
          next_start_q = 1'b1;
          next_st      = aam_pkg::SQ_CONV;
        end
      end
      aam_pkg::SQ_CONV: begin
        if (is_temp[ch]) tmr_done = timer[13:0] == HALF_LAST;
        else tmr_done = timer[13:0] == VOLT_LAST;
        if (tmr_done) begin
          next_timer = 16'h0000;
          if (is_temp[ch] && !phase) begin
            next_first   = CONV_DATA;
            next_phase   = 1'b1;
            next_start_q = 1'b1;
          end else begin
            next_phase   = 1'b0;
            next_acc     = sum;
            next_avg_cnt = avg_cnt + 4'h1;
            next_st      = avg_last ? aam_pkg::SQ_EVAL : aam_pkg::SQ_ACQ;
          end
        end
      end
      aam_pkg::SQ_EVAL: begin
        mem_we       = 1'b1;
        next_avg_cnt = 4'h0;
        next_acc     = 16'h0000;
        next_timer   = 16'h0000;
        if (over) begin
          next_fcnt[ch] = fc_inc;
          if (fc_inc > fault_allow) next_alarm[ch] = 1'b1;
        end else begin
          next_fcnt[ch] = 4'h0;
        end
        if (manual) next_st = aam_pkg::SQ_IDLE;
        else if (nxt != 5'h1f) begin
          next_ch = 4'(nxt);
          next_st = aam_pkg::SQ_ACQ;
        end else next_st = aam_pkg::SQ_WAIT;
      end
      aam_pkg::SQ_WAIT: begin
        if (timer >= delay) next_st = aam_pkg::SQ_IDLE;
      end
      default: next_st = aam_pkg::SQ_IDLE;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (clr_all || (clr_one && cmd_word[3:0] == 4'(i)) ||
          (apb_wr && PADDR == `AAM_OFF_ALARM && PWDATA[i]) || soft_rst) begin
        if (!(st == aam_pkg::SQ_EVAL && 4'(i) == ch && next_alarm[i] &&
              !alarm[i])) begin
          next_alarm[i] = 1'b0;
        end
        next_fcnt[i] = 4'h0;
      end
    end
    if (soft_rst) begin
      next_st       = aam_pkg::SQ_IDLE;
      next_man_pend = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st       <= aam_pkg::SQ_IDLE;
      ch       <= 4'h0;
      man_ch   <= 4'h0;
      man_pend <= 1'b0;
      manual   <= 1'b0;
      phase    <= 1'b0;
      timer    <= 16'h0000;
      avg_cnt  <= 4'h0;
      acc      <= 16'h0000;
      first    <= 12'h000;
      start_q  <= 1'b0;
      alarm    <= 10'h000;
      for (int i = 0; i < NCH; i++) fcnt[i] <= 4'h0;
    end else begin
      st       <= next_st;
      ch       <= next_ch;
      man_ch   <= next_man_ch;
      man_pend <= next_man_pend;
      manual   <= next_manual;
      phase    <= next_phase;
      timer    <= next_timer;
      avg_cnt  <= next_avg_cnt;
      acc      <= next_acc;
      first    <= next_first;
      start_q  <= next_start_q;
      alarm    <= next_alarm;
      for (int i = 0; i < NCH; i++) fcnt[i] <= next_fcnt[i];
    end
  end

  assign CONV_START = start_q;
  assign CONV_CHAN  = ch;
  assign CONV_DIFF  = is_diff[ch];
  assign CONV_TEMP  = is_temp[ch];

  logic int_level;
  assign int_level = (|alarm) ~^ pol_high;
  assign INT_O     = odrain ? 1'b0 : int_level;
  assign INT_OE    = odrain ? ~int_level : 1'b1;

endmodule // aam_top

`default_nettype wire

// [tb/aam_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module aam_asserts (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       CS_N,
  input wire logic       SCLK,
  input wire logic       DOUT,
  input wire logic       DOUT_OE,
  input wire logic       INT_O,
  input wire logic       INT_OE,
  input wire logic       CONV_START,
  input wire logic [3:0] CONV_CHAN,
  input wire logic       CONV_DIFF,
  input wire logic       CONV_TEMP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Long enough to pass the select synchroniser
  sequence cs_idle_s; CS_N [*5]; endsequence
  sequence start_s; CONV_START; endsequence
  oe_off_a: assert property (cs_idle_s |-> !DOUT_OE)
    else $error("serial output driven while deselected");
  dout_fall_a: assert property ($changed(DOUT) && !CS_N && !$past(CS_N, 4)
    |-> !SCLK) else $error("serial output moved while clock high");
  start_gap_a: assert property (start_s |=> !CONV_START [*8])
    else $error("conversion restarted too soon");
  chan_hold_a: assert property (start_s |=> $stable(CONV_CHAN) [*8])
    else $error("channel changed during conversion");
  chan_range_a: assert property (start_s |-> CONV_CHAN < 4'ha)
    else $error("conversion of a channel beyond nine");
  diff_even_a: assert property (start_s and CONV_DIFF
    |-> !CONV_CHAN[0] && CONV_CHAN >= 4'h2) else $error("bad pair");
  temp_ch0_a: assert property (start_s and CONV_CHAN == 4'h0
    |-> CONV_TEMP) else $error("die channel not in temperature mode");
  int_drive_a: assert property (INT_O |-> INT_OE)
    else $error("interrupt high while undriven");
endmodule // aam_asserts
bind aam_top aam_asserts u_chk (.CLK(CLK), .RESET_N(RESET_N), .CS_N(CS_N),
  .SCLK(SCLK), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .INT_O(INT_O),
  .INT_OE(INT_OE), .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN),
  .CONV_DIFF(CONV_DIFF), .CONV_TEMP(CONV_TEMP));
`default_nettype wire

// [tb/aam_host.sv]
`timescale 1ns/1ps
`default_nettype none
module aam_host (
  output logic    cs_n,
  output logic    sclk,
  output logic    din,
  input wire logic dout,
  input wire logic dout_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input int n,
                      output logic [23:0] q);
    q = 24'h000000;
    cs_n <= 1'b0;
    #40;
    for (int i = 0; i < 8 + n; i++) begin
      din <= (i < 8) ? cmd[7-i] : 1'b0;
      #32 sclk <= 1'b1;
      // Released line reads as pulled high
      if (i >= 8) q = {q[22:0], dout_oe ? dout : 1'b1};
      #32 sclk <= 1'b0;
    end
    #40 cs_n <= 1'b1;
    din <= ~din;
    #100;
  endtask
endmodule // aam_host
`default_nettype wire

// [tb/autonomous_adc_monitor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module autonomous_adc_monitor_tb;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, dout, dout_oe, int_o, int_oe;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [11:0] conv_data = 12'h900;
  wire logic cs_n, sclk, din;
  int bad_count = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  aam_top #(.ACQ_CYC(8), .VOLT_CYC(20), .TEMP_CYC(40)) i_dut (.CLK(clk),
    .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout),
    .DOUT_OE(dout_oe), .INT_O(int_o), .INT_OE(int_oe), .CONV_START(),
    .CONV_CHAN(), .CONV_DIFF(), .CONV_TEMP(), .CONV_DATA(conv_data));
  aam_host i_host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
  initial begin
    logic [31:0] q;
    logic [23:0] s;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0, q);
    chk("enable", 32'h3ff, q);
    apb(1'b0, 8'h88, 32'h0, q);
    chk("threshold", 32'h0fff0000, q);
    apb(1'b0, 8'hfc, 32'h0, q);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 8'h88, 32'h08000100, q);
    // Die channel is signed: full signed range keeps it quiet
    apb(1'b1, 8'h80, 32'h07ff0800, q);
    apb(1'b1, 8'h48, 32'h1, q);
    apb(1'b1, 8'h04, 32'h5, q);
    // Scan on, push-pull active high, one fault cycle allowed
    apb(1'b1, 8'h00, 32'h105, q);
    for (int k = 0; k < 2; k++) begin
      conv_data <= 12'h900;
      repeat (400) @(posedge clk);
      apb(1'b0, 8'hc8, 32'h0, q);
      chk("data", 32'h900, q);
      i_host.xfer(8'h22, 16, s);
      chk("serial data", 32'h9000, {8'h00, s});
      i_host.xfer(8'h10, 24, s);
      chk("serial alarm", 32'h4, {8'h00, s});
      conv_data <= 12'h400;
      repeat (100) @(posedge clk);
      apb(1'b0, 8'h0c, 32'h0, q);
      chk("held alarm", 32'h4, q);
      chk("interrupt", 32'h1, {31'h0, int_o});
      chk("interrupt drive", 32'h1, {31'h0, int_oe});
      i_host.xfer(k == 0 ? 8'h82 : 8'h90, 0, s);
      apb(1'b0, 8'h0c, 32'h0, q);
      chk("cleared alarm", 32'h0, q);
      chk("interrupt off", 32'h0, {31'h0, int_o});
    end
    // Scan off, two-sample averaging, then one manual conversion
    apb(1'b1, 8'h00, 32'h114, q);
    repeat (100) @(posedge clk);
    conv_data <= 12'h300;
    i_host.xfer(8'h02, 0, s);
    repeat (100) @(posedge clk);
    apb(1'b0, 8'hc8, 32'h0, q);
    chk("manual data", 32'h300, q);
    i_host.xfer(8'h70, 0, s);
    apb(1'b0, 8'h00, 32'h0, q);
    chk("reset control", 32'h0, q);
    complete_run;
  end
endmodule // autonomous_adc_monitor_tb
`default_nettype wire
